/* verilog/bsc_power_ctrl.sv */
// Brown-out sleep-off control and peripheral clock gating, APB slave.
// Assumes one clock pclk and a sleep level from the core on that clock, held high for the whole sleep.
//
// What this block does
// - The brown-out detector is switched off in sleep only after the sleep-off bit was written to one.
// - The sleep-off bit can only be set through a timed sequence qualified by an unlock bit.
// - Within four cycles software writes sleep-off one with unlock zero, and the bit is then set.
// - The sleep-off bit becomes effective three cycles after it is set.
// - The detector is disabled only for a sleep that starts while the bit is effective.
// - Hardware clears the sleep-off bit automatically three cycles after it took effect.
// - The clock gate register is 8 bits, resets to zero, bits 7 and 6 read zero, bits 5..0 gate six peripherals.
// - A set gate bit stops that peripheral's clock, freezes it and blocks its register access.
`timescale 1ns/1ns

module bsc_power_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_exec,
    output logic             brownout_detector_off,
    output bsc_pkg::bsc_gates_t clk_gate,
    output bsc_pkg::bsc_gates_t reg_block
);

    logic [7:0] peripheral_clock_gate;
    logic [7:0] next_gate;
    logic       bod_off;
    logic       next_bod_off;
    logic       wr_en;
    logic       wr_ctrl;
    logic       sleep_off;
    logic       sleep_off_active;
    logic       window_missed;
    logic       unlock_seen;
    logic       next_unlock_seen;
    logic       sleep_prev;
    logic       next_sleep_prev;
    logic [31:0] next_prdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // ========================================================================
    // APB decode
    // ========================================================================
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign wr_ctrl = wr_en && hit(paddr, bsc_pkg::ADDR_CORE_CTRL);
    assign pslverr = psel && penable
                  && !hit(paddr, bsc_pkg::ADDR_CORE_CTRL)
                  && !hit(paddr, bsc_pkg::ADDR_CLOCK_GATE)
                  && !hit(paddr, bsc_pkg::ADDR_STATUS);

    // ========================================================================
    // Unlock sequence
    // ========================================================================
    bsc_unlock_seq u_seq (
        .pclk             (pclk),
        .presetn          (presetn),
        .wr_ctrl          (wr_ctrl),
        .wr_off           (pwdata[bsc_pkg::BIT_SLEEP_OFF]),
        .wr_unlock        (pwdata[bsc_pkg::BIT_SLEEP_UNLOCK]),
        .sleep_off        (sleep_off),
        .sleep_off_active (sleep_off_active),
        .window_missed    (window_missed)
    );

    // ========================================================================
    // Register and sleep state
    // ========================================================================
    always_comb begin
        next_gate        = peripheral_clock_gate;
        next_bod_off     = bod_off;
        next_unlock_seen = unlock_seen;
        next_sleep_prev  = sleep_exec;
        if (wr_en && hit(paddr, bsc_pkg::ADDR_CLOCK_GATE)) begin
            next_gate = pwdata[7:0] & bsc_pkg::GATE_WMASK;
        end
        if (wr_ctrl) begin
            next_unlock_seen = pwdata[bsc_pkg::BIT_SLEEP_UNLOCK];
        end
        // The detector state is decided at sleep entry and kept until wake,
        // so the bit clearing itself mid-sleep does not wake the detector.
        if (sleep_exec && !sleep_prev) begin
            next_bod_off = sleep_off_active;
        end else if (!sleep_exec) begin
            next_bod_off = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_clock_gate <= bsc_pkg::GATE_RESET;
            bod_off               <= 1'b0;
            unlock_seen           <= 1'b0;
            sleep_prev            <= 1'b0;
        end else begin
            peripheral_clock_gate <= next_gate;
            bod_off               <= next_bod_off;
            unlock_seen           <= next_unlock_seen;
            sleep_prev            <= next_sleep_prev;
        end
    end

    // ========================================================================
    // Read data
    // ========================================================================
    always_comb begin
        next_prdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, bsc_pkg::ADDR_CORE_CTRL)) begin
                next_prdata[bsc_pkg::BIT_SLEEP_OFF]    = sleep_off;
                next_prdata[bsc_pkg::BIT_SLEEP_UNLOCK] = unlock_seen;
            end else if (hit(paddr, bsc_pkg::ADDR_CLOCK_GATE)) begin
                next_prdata[7:0] = peripheral_clock_gate;
            end else if (hit(paddr, bsc_pkg::ADDR_STATUS)) begin
                next_prdata[0] = sleep_off_active;
                next_prdata[1] = window_missed;
                next_prdata[2] = bod_off;
            end
        end else if (psel && penable) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else begin
            prdata <= next_prdata;
        end
    end

    // ========================================================================
    // Outputs to the peripherals
    // ========================================================================
    assign brownout_detector_off = bod_off;
    assign clk_gate.lin  = peripheral_clock_gate[bsc_pkg::BIT_GATE_LIN];
    assign clk_gate.spi  = peripheral_clock_gate[bsc_pkg::BIT_GATE_SPI];
    assign clk_gate.tim1 = peripheral_clock_gate[bsc_pkg::BIT_GATE_TIM1];
    assign clk_gate.tim0 = peripheral_clock_gate[bsc_pkg::BIT_GATE_TIM0];
    assign clk_gate.usi  = peripheral_clock_gate[bsc_pkg::BIT_GATE_USI];
    assign clk_gate.adc  = peripheral_clock_gate[bsc_pkg::BIT_GATE_ADC];
    // Register access is blocked exactly while the clock is stopped.
    assign reg_block = clk_gate;

endmodule

/* verilog/bsc_pkg.sv */
// Package of the brown-out sleep and clock gating block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package bsc_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] ADDR_CORE_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_GATE = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int BIT_SLEEP_OFF    = 6;
    localparam int BIT_SLEEP_UNLOCK = 5;
    localparam int BIT_GATE_LIN     = 5;
    localparam int BIT_GATE_SPI     = 4;
    localparam int BIT_GATE_TIM1    = 3;
    localparam int BIT_GATE_TIM0    = 2;
    localparam int BIT_GATE_USI     = 1;
    localparam int BIT_GATE_ADC     = 0;

    // ========================================================================
    // Reset values and masks
    // ========================================================================
    localparam logic [7:0] GATE_RESET    = 8'h00;
    localparam logic [7:0] GATE_WMASK    = 8'h3f;

    // ========================================================================
    // Timing counts in clock cycles
    // ========================================================================
    localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
    localparam logic [2:0] ARM_DELAY     = 3'h3;
    localparam logic [2:0] ARM_HOLD      = 3'h3;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        BSC_IDLE   = 2'b00,
        BSC_OPEN   = 2'b01,
        BSC_DELAY  = 2'b10,
        BSC_ACTIVE = 2'b11
    } bsc_state_t;

    typedef struct packed {
        logic lin;
        logic spi;
        logic tim1;
        logic tim0;
        logic usi;
        logic adc;
    } bsc_gates_t;

endpackage

/* verilog/bsc_unlock_seq.sv */
// Timed unlock sequence that arms the brown-out sleep-off bit.
// Assumes single-cycle write pulses from the register logic on pclk.
`timescale 1ns/1ns

module bsc_unlock_seq (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic wr_ctrl,
    input  wire logic wr_off,
    input  wire logic wr_unlock,
    output logic      sleep_off,
    output logic      sleep_off_active,
    output logic      window_missed
);

    bsc_pkg::bsc_state_t state;
    bsc_pkg::bsc_state_t next_state;
    logic [2:0]          count;
    logic [2:0]          next_count;
    logic                missed;
    logic                next_missed;

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        next_state  = state;
        next_count  = count;
        next_missed = missed;
        case (state)
            bsc_pkg::BSC_IDLE: begin
                next_count = 3'h0;
            end
            bsc_pkg::BSC_OPEN: begin
                if (wr_ctrl && wr_off && !wr_unlock) begin
                    next_state = bsc_pkg::BSC_DELAY;
                    next_count = 3'h0;
                end else if (count == bsc_pkg::UNLOCK_WINDOW - 3'h1) begin
                    next_state  = bsc_pkg::BSC_IDLE;
                    next_missed = 1'b1;
                end else begin
                    next_count = count + 3'h1;
                end
            end
            bsc_pkg::BSC_DELAY: begin
                if (count == bsc_pkg::ARM_DELAY - 3'h1) begin
                    next_state = bsc_pkg::BSC_ACTIVE;
                    next_count = 3'h0;
                end else begin
                    next_count = count + 3'h1;
                end
            end
            bsc_pkg::BSC_ACTIVE: begin
                // Active window ends three cycles after the bit went active.
                if (count == bsc_pkg::ARM_HOLD - 3'h1) begin
                    next_state = bsc_pkg::BSC_IDLE;
                    next_count = 3'h0;
                end else begin
                    next_count = count + 3'h1;
                end
            end
            default: begin
                next_state = bsc_pkg::BSC_IDLE;
                next_count = 3'h0;
            end
        endcase
        // An opening write restarts the sequence from any state.
        if (wr_ctrl && wr_off && wr_unlock) begin
            next_state  = bsc_pkg::BSC_OPEN;
            next_count  = 3'h0;
            next_missed = 1'b0;
        end
    end

    // ========================================================================
    // State registers
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= bsc_pkg::BSC_IDLE;
            count  <= 3'h0;
            missed <= 1'b0;
        end else begin
            state  <= next_state;
            count  <= next_count;
            missed <= next_missed;
        end
    end

    assign sleep_off = (state == bsc_pkg::BSC_DELAY)
                    || (state == bsc_pkg::BSC_ACTIVE);
    assign sleep_off_active = (state == bsc_pkg::BSC_ACTIVE);
    assign window_missed    = missed;

endmodule

/* test/bsc_power_ctrl_chk.sv */
// Port checker of the power control block.
// Assumes it is bound to bsc_power_ctrl, single pclk domain.
`timescale 1ns/1ns

module bsc_power_ctrl_chk (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                sleep_exec,
    input wire logic                brownout_detector_off,
    input wire bsc_pkg::bsc_gates_t clk_gate,
    input wire bsc_pkg::bsc_gates_t reg_block
);
    // ========================================================================
    // Cycles since the last arming write
    // ========================================================================
    logic       acc;
    logic       gate_wr;
    logic [5:0] gate_wdata;
    logic [3:0] since_arm;
    logic [3:0] next_since_arm;

    assign acc        = psel & penable;
    assign gate_wr    = acc & pwrite & (paddr == bsc_pkg::ADDR_CLOCK_GATE);
    assign gate_wdata = pwdata[5:0];

    always_comb begin
        next_since_arm = since_arm;
        if (acc && pwrite && paddr == bsc_pkg::ADDR_CORE_CTRL &&
            pwdata[bsc_pkg::BIT_SLEEP_OFF] &&
            !pwdata[bsc_pkg::BIT_SLEEP_UNLOCK]) begin
            next_since_arm = 4'h0;
        end else if (since_arm != 4'hf) begin
            next_since_arm = since_arm + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_arm <= 4'hf;
        end else begin
            since_arm <= next_since_arm;
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_gate_reset: assert property ($rose(presetn) |-> clk_gate == 6'h00)
        else $error("clock gates not zero after reset");
    a_gate_mirror: assert property (clk_gate == reg_block)
        else $error("access block differs from clock gate");
    a_gate_write: assert property (gate_wr |=> clk_gate == $past(gate_wdata))
        else $error("clock gate write not applied");
    a_gate_stable: assert property (!gate_wr |=> $stable(clk_gate))
        else $error("clock gate changed without a write");
    a_gate_read: assert property (acc && !pwrite &&
        paddr == bsc_pkg::ADDR_CLOCK_GATE |-> prdata == {26'h0, clk_gate})
        else $error("clock gate read data wrong");
    a_off_idle: assert property (!sleep_exec |=> !brownout_detector_off)
        else $error("detector off outside a sleep");
    a_off_hold: assert property (brownout_detector_off && sleep_exec |=>
        brownout_detector_off)
        else $error("detector back on during a sleep");
    a_off_rise: assert property ($rose(brownout_detector_off) |->
        $past(sleep_exec) && !$past(sleep_exec, 2))
        else $error("detector off not started by sleep entry");
    a_off_window: assert property ($rose(brownout_detector_off) |->
        since_arm inside {[3:6]})
        else $error("detector off outside the armed interval");
endmodule

bind bsc_power_ctrl bsc_power_ctrl_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .brownout_detector_off(brownout_detector_off),
    .clk_gate(clk_gate), .reg_block(reg_block)
);

/* test/tb.sv */
// Self-checking bench of the power control block.
// Assumes a zero-wait APB slave on a 25 MHz pclk.
`timescale 1ns/1ns

module tb;
    logic                pclk       = 1'b0;
    logic                presetn    = 1'b0;
    logic                psel       = 1'b0;
    logic                penable    = 1'b0;
    logic                pwrite     = 1'b0;
    logic [7:0]          paddr      = 8'h00;
    logic [31:0]         pwdata     = 32'h0;
    logic                sleep_exec = 1'b0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                brownout_detector_off;
    bsc_pkg::bsc_gates_t clk_gate;
    bsc_pkg::bsc_gates_t reg_block;
    int                  num_errors = 0;
    int                  checked    = 0;
    int                  cyc        = 0;

    bsc_power_ctrl u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
        .brownout_detector_off(brownout_detector_off),
        .clk_gate(clk_gate), .reg_block(reg_block)
    );

    always #20 pclk = ~pclk;

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // The request is left standing; idle releases it.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
    endtask

    task automatic idle(input int n);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            final_report();
        end
    end

    // ========================================================================
    // Scenarios
    // ========================================================================
    initial begin
        logic [31:0] r;
        logic        e;
        logic [31:0] d;
        int          gate_m;
        int          arm;
        int          gaps[$];
        int          waits[$];
        gaps  = '{0, 1, 2, 4, 0, 0};
        waits = '{3, 3, 3, 3, 7, 1};
        d = $urandom(61940);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, 8'(a), 32'h0, r, e);
            idle(1);
            chk("reset_read", 32'h0, r);
        end
        apb(1'b0, 8'h0c, 32'h0, r, e);
        idle(1);
        chk("unmapped_err", 32'h1, {31'h0, e});
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'hffffffff : $urandom;
            gate_m = int'(d & {24'h0, bsc_pkg::GATE_WMASK});
            apb(1'b1, bsc_pkg::ADDR_CLOCK_GATE, d, r, e);
            idle(1);
            chk("clk_gate", gate_m, {26'h0, clk_gate});
            chk("reg_block", gate_m, {26'h0, reg_block});
            apb(1'b0, bsc_pkg::ADDR_CLOCK_GATE, 32'h0, r, e);
            idle(1);
            chk("gate_read", gate_m, r);
        end
        foreach (gaps[i]) begin
            apb(1'b1, bsc_pkg::ADDR_CORE_CTRL, 32'h60, r, e);
            if (gaps[i] > 0) idle(gaps[i]);
            apb(1'b1, bsc_pkg::ADDR_CORE_CTRL, 32'h40, r, e);
            idle(waits[i]);
            sleep_exec <= 1'b1;
            repeat (5) @(posedge pclk);
            arm = (2 + gaps[i] <= 4) ? 1 : 0;
            chk("detector_off", (waits[i] == 3) ? arm : 0,
                {31'h0, brownout_detector_off});
            sleep_exec <= 1'b0;
            idle(8);
            chk("off_after_wake", 32'h0, {31'h0, brownout_detector_off});
            apb(1'b0, bsc_pkg::ADDR_STATUS, 32'h0, r, e);
            idle(1);
            chk("status", (1 - arm) * 2, r);
            apb(1'b0, bsc_pkg::ADDR_CORE_CTRL, 32'h0, r, e);
            idle(1);
            chk("sleep_off_clear", 32'h0, r);
        end
        final_report();
    end
endmodule
